//--- sep_pkg.sv
// Shared constants of the serial memory read path.
package sep_pkg;

  // Device type code of the control byte; the value is arbitrary.
  localparam logic [3:0]  SEP_DEV_TYPE     = 4'h5;
  localparam int          SEP_ADDR_W       = 15;
  localparam logic [14:0] SEP_ADDR_TOP     = 15'h7fff;
  localparam logic [14:0] SEP_ADDR_BOTTOM  = 15'h0000;
  localparam logic [14:0] SEP_PTR_RST      = 15'h0000;
  localparam logic [2:0]  SEP_BIT_LAST     = 3'h7;
  localparam logic [3:0]  SEP_ACK_SLOT     = 4'h8;
  localparam logic        SEP_SCL_IDLE     = 1'b1;
  localparam logic        SEP_RW_READ      = 1'b1;
  localparam logic        SEP_RW_WRITE     = 1'b0;

  // Serial clock half period made by the master.
  localparam int          SEP_REF_PERIOD_PS = 5000;
  localparam int          SEP_SCL_HALF_NS   = 1250;
  localparam int          SEP_SCL_HALF_CYC  =
    (SEP_SCL_HALF_NS * 1000 + SEP_REF_PERIOD_PS - 1) / SEP_REF_PERIOD_PS;

endpackage : sep_pkg

//--- sep_link_if.sv
// Two-wire link between the bus master and the memory read path.
`timescale 1ns/1ps
interface sep_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;

  // Open drain: the line is low whenever an enabled driver pulls it low.
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (
    output scl,
    output sda_m_o,
    output sda_m_oe,
    input  sda
  );

  modport slave (
    input  scl,
    input  sda,
    output sda_s_o,
    output sda_s_oe
  );
endinterface : sep_link_if

//--- sep_dev.sv
// Memory end of the link: control byte decode, address pointer, reads.
// Functional notes
// - Pointer holds last accessed address plus one.
// - Matching read control byte: acknowledge, send byte.
// - Master no-acknowledge then stop ends the read.
// - Master loads word address with write byte.
// - Repeated start abandons write, keeps new pointer.
// - Read control after repeated start returns byte.
// - After random read pointer is next address.
// - Master acknowledge asks for next sequential byte.
// - Master ends sequential read: no-acknowledge, stop.
// - Pointer advances by one per sent byte.
// - Sending the top address byte wraps pointer to bottom.
// - Acknowledge only matching type and chip selects.
// - Last control bit selects read or write.
// - No acknowledge at all while programming runs.
// - Address arrives high byte first, top bit ignored.
`timescale 1ns/1ps
module sep_dev (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  sep_link_if.slave                          link,
  input  wire logic [2:0]                    chip_select_inputs,
  input  wire logic                          prog_busy,
  input  wire logic [7:0]                    rd_data,
  output logic      [sep_pkg::SEP_ADDR_W-1:0] rd_addr,
  output logic                               reading,
  output logic                               byte_sent
);
  import sep_pkg::*;

  typedef enum logic [3:0] {
    D_IDLE,
    D_CTRL,
    D_AHI,
    D_ALO,
    D_WDAT,
    D_ACK,
    D_TX,
    D_MACK,
    D_SKIP
  } sep_dev_state_t;

  typedef struct packed {
    sep_dev_state_t st;
    sep_dev_state_t after_ack;
    logic [2:0]     scl_sy;
    logic [2:0]     sda_sy;
    logic [1:0][2:0] cs_sy;
    logic [7:0]     sr;
    logic [2:0]     cnt;
    logic           got;
    logic [6:0]     ahi;
    logic [14:0]    ptr;
    logic           mack;
    logic           oe;
    logic           rd;
    logic           sent;
  } sep_dev_s_t;

  sep_dev_s_t s;
  sep_dev_s_t next_s;

  logic scl;
  logic scl_d;
  logic sda;
  logic sda_d;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ack;
  logic match;

  assign scl   = s.scl_sy[1];
  assign scl_d = s.scl_sy[2];
  assign sda   = s.sda_sy[1];
  assign sda_d = s.sda_sy[2];
  assign rise  = scl & ~scl_d;
  assign fall  = ~scl & scl_d;
  // A data change while the clock is high is a start or a stop.
  assign start = scl & scl_d & sda_d & ~sda;
  assign stop  = scl & scl_d & ~sda_d & sda;
  assign match = (s.sr[7:4] == SEP_DEV_TYPE) && (s.sr[3:1] == s.cs_sy[1]);

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_s = s;
    ack = 1'b0;
    next_s.sent = 1'b0;
    next_s.scl_sy = {s.scl_sy[1:0], link.scl};
    next_s.sda_sy = {s.sda_sy[1:0], link.sda};
    next_s.cs_sy = {s.cs_sy[0], chip_select_inputs};
    if (stop) begin
      next_s.st = D_IDLE;
      next_s.oe = 1'b0;
      next_s.rd = 1'b0;
    end else if (start) begin
      // A repeated start drops any write; the pointer stays as loaded.
      next_s.st = D_CTRL;
      next_s.cnt = 3'h0;
      next_s.got = 1'b0;
      next_s.oe = 1'b0;
      next_s.rd = 1'b0;
    end else begin
      unique case (s.st)
        D_IDLE, D_SKIP: begin
        end
        D_CTRL, D_AHI, D_ALO, D_WDAT: begin
          if (rise) begin
            next_s.sr = {s.sr[6:0], sda};
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == SEP_BIT_LAST) begin
              next_s.got = 1'b1;
            end
          end else if (fall && s.got) begin
            next_s.got = 1'b0;
            next_s.cnt = 3'h0;
            if (s.st == D_CTRL) begin
              ack = match && !prog_busy;
              if (s.sr[0] == SEP_RW_READ) begin
                next_s.after_ack = D_TX;
              end else begin
                next_s.after_ack = D_AHI;
              end
            end else if (s.st == D_AHI) begin
              ack = !prog_busy;
              next_s.ahi = s.sr[6:0];
              next_s.after_ack = D_ALO;
            end else if (s.st == D_ALO) begin
              ack = !prog_busy;
              next_s.ptr = {s.ahi, s.sr};
              next_s.after_ack = D_WDAT;
            end else begin
              // Written data is taken and dropped; this path never programs.
              ack = !prog_busy;
              next_s.after_ack = D_WDAT;
            end
            if (ack) begin
              next_s.oe = 1'b1;
              next_s.st = D_ACK;
            end else begin
              next_s.st = D_SKIP;
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            next_s.oe = 1'b0;
            next_s.cnt = 3'h0;
            next_s.st = s.after_ack;
            if (s.after_ack == D_TX) begin
              next_s.sr = rd_data;
              next_s.oe = ~rd_data[7];
              next_s.rd = 1'b1;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (s.cnt == SEP_BIT_LAST) begin
              next_s.oe = 1'b0;
              next_s.mack = 1'b0;
              next_s.st = D_MACK;
              next_s.sent = 1'b1;
              if (s.ptr == SEP_ADDR_TOP) begin
                next_s.ptr = SEP_ADDR_BOTTOM;
              end else begin
                next_s.ptr = s.ptr + 15'h1;
              end
            end else begin
              next_s.sr = {s.sr[6:0], 1'b0};
              next_s.oe = ~s.sr[6];
              next_s.cnt = s.cnt + 3'h1;
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            next_s.mack = ~sda;
          end else if (fall) begin
            if (s.mack) begin
              next_s.st = D_TX;
              next_s.sr = rd_data;
              next_s.oe = ~rd_data[7];
              next_s.cnt = 3'h0;
            end else begin
              // Line left released so the master can make its stop.
              next_s.st = D_SKIP;
              next_s.rd = 1'b0;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.ptr <= SEP_PTR_RST;
      // Synchronisers start at the idle level, so that release shows no false edge.
      s.scl_sy <= {3{SEP_SCL_IDLE}};
      s.sda_sy <= {3{SEP_SCL_IDLE}};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = s.oe;
  assign rd_addr       = s.ptr;
  assign reading       = s.rd;
  assign byte_sent     = s.sent;

endmodule : sep_dev

//--- sep_host.sv
// Master end of the link: makes the serial clock and runs read commands.
`timescale 1ns/1ps
module sep_host #(
  parameter int HALF_CYC = sep_pkg::SEP_SCL_HALF_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  sep_link_if.master                         link,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_random,
  input  wire logic [2:0]                    cmd_cs,
  input  wire logic [sep_pkg::SEP_ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]                    cmd_len,
  output logic                               cmd_ready,
  output logic                               rd_valid,
  output logic      [7:0]                    rd_byte,
  output logic                               done,
  output logic                               nack
);
  import sep_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_COND, H_BIT, H_STOP} sep_host_state_t;
  typedef enum logic [2:0] {S_CW, S_AH, S_AL, S_CR, S_RD} sep_step_t;

  typedef struct packed {
    sep_host_state_t st;
    sep_step_t       step;
    logic [1:0]      ph;
    logic [3:0]      bi;
    logic            hb;
    logic [15:0]     div;
    logic [8:0]      tx;
    logic [7:0]      rx;
    logic [7:0]      left;
    logic [14:0]     addr;
    logic [2:0]      cs;
    logic [1:0]      sda_sy;
    logic            scl;
    logic            sda_low;
    logic            ready;
    logic            vld;
    logic [7:0]      byt;
    logic            done;
    logic            nack;
  } sep_host_s_t;

  sep_host_s_t s;
  sep_host_s_t next_s;
  logic        tick;
  logic        sda;

  assign tick = (s.div == 16'(HALF_CYC - 1));
  assign sda  = s.sda_sy[1];

  // Starts a nine-bit slot with the clock low and the first bit set up.
  function automatic sep_host_s_t put(sep_host_s_t x, logic [8:0] bits);
    x.tx = bits;
    x.sda_low = ~bits[8];
    x.st = H_BIT;
    x.bi = 4'h0;
    x.hb = 1'b0;
    x.scl = 1'b0;
    return x;
  endfunction : put

  function automatic sep_host_s_t halt(sep_host_s_t x);
    x.st = H_STOP;
    x.ph = 2'h0;
    x.scl = 1'b0;
    x.sda_low = 1'b1;
    return x;
  endfunction : halt

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_s = s;
    next_s.vld = 1'b0;
    next_s.done = 1'b0;
    next_s.sda_sy = {s.sda_sy[0], link.sda};
    next_s.div = tick ? 16'h0 : s.div + 16'h1;
    unique case (s.st)
      H_IDLE: begin
        next_s.div = 16'h0;
        next_s.ready = 1'b1;
        if (cmd_valid && s.ready) begin
          next_s.ready = 1'b0;
          next_s.nack = 1'b0;
          next_s.addr = cmd_addr;
          next_s.cs = cmd_cs;
          next_s.left = (cmd_len == 8'h0) ? 8'h1 : cmd_len;
          next_s.step = cmd_random ? S_CW : S_CR;
          next_s.st = H_COND;
          next_s.ph = 2'h2;
          next_s.sda_low = 1'b1;
        end
      end
      H_COND: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          unique case (s.ph)
            2'h0: next_s.scl = 1'b1;
            2'h1: next_s.sda_low = 1'b1;
            2'h2: next_s.scl = 1'b0;
            2'h3: next_s = put(next_s, {SEP_DEV_TYPE, s.cs,
                                   (s.step == S_CW) ? SEP_RW_WRITE : SEP_RW_READ,
                                   1'b1});
          endcase
        end
      end
      H_BIT: begin
        if (tick && !s.hb) begin
          next_s.scl = 1'b1;
          next_s.hb = 1'b1;
        end else if (tick) begin
          next_s.scl = 1'b0;
          next_s.hb = 1'b0;
          if (s.bi != SEP_ACK_SLOT) begin
            next_s.rx = {s.rx[6:0], sda};
            next_s.bi = s.bi + 4'h1;
            next_s.tx = {s.tx[7:0], 1'b1};
            next_s.sda_low = ~s.tx[7];
          end else if (sda && s.step != S_RD) begin
            next_s.nack = 1'b1;
            next_s = halt(next_s);
          end else begin
            unique case (s.step)
              S_CW: begin
                next_s.step = S_AH;
                next_s = put(next_s, {1'b0, s.addr[14:8], 1'b1});
              end
              S_AH: begin
                next_s.step = S_AL;
                next_s = put(next_s, {s.addr[7:0], 1'b1});
              end
              S_AL: begin
                // Repeated start instead of data turns the write into a read.
                next_s.step = S_CR;
                next_s.st = H_COND;
                next_s.ph = 2'h0;
                next_s.sda_low = 1'b0;
              end
              S_CR: begin
                next_s.step = S_RD;
                next_s = put(next_s, {8'hff, s.left == 8'h1});
              end
              S_RD: begin
                next_s.vld = 1'b1;
                next_s.byt = s.rx;
                next_s.left = s.left - 8'h1;
                if (s.left == 8'h1) begin
                  next_s = halt(next_s);
                end else begin
                  next_s = put(next_s, {8'hff, s.left == 8'h2});
                end
              end
            endcase
          end
        end
      end
      H_STOP: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          if (s.ph == 2'h0) begin
            next_s.scl = 1'b1;
          end else if (s.ph == 2'h1) begin
            next_s.sda_low = 1'b0;
          end else begin
            next_s.st = H_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.scl <= SEP_SCL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl      = s.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = s.sda_low;
  assign cmd_ready     = s.ready;
  assign rd_valid      = s.vld;
  assign rd_byte       = s.byt;
  assign done          = s.done;
  assign nack          = s.nack;

endmodule : sep_host

//--- sep_link_properties.sv
// Protocol checks on the link between the host end and the memory end.
`timescale 1ns/1ps
module sep_link_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda
);
  typedef struct packed {
    logic       scl_q;
    logic       sda_q;
    logic       ctrl;
    logic [3:0] bitc;
  } sep_chk_t;

  sep_chk_t st;
  sep_chk_t next_st;
  logic     start;
  logic     stop;
  logic     rise;

  assign start = scl & st.scl_q & st.sda_q & ~sda;
  assign stop  = scl & st.scl_q & ~st.sda_q & sda;
  assign rise  = scl & ~st.scl_q;

  // Bit slots are counted from each start, so slot 8 is the acknowledge slot.
  always_comb begin
    next_st = st;
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    if (start) begin
      next_st.bitc = 4'h0;
      next_st.ctrl = 1'b1;
    end else if (rise) begin
      next_st.bitc = (st.bitc == 4'h8) ? 4'h0 : st.bitc + 4'h1;
      next_st.ctrl = st.ctrl & (st.bitc != 4'h8);
    end
    if (rst) begin
      next_st = '{scl_q: 1'b1, sda_q: 1'b1, ctrl: 1'b0, bitc: 4'h0};
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence dev_quiet;
    !sda_s_oe [*8];
  endsequence

  a_dev_change_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("memory end changed the data line while the clock was high");
  a_dev_hold_high: assert property ($rose(scl) |=> $stable(sda_s_oe) [*4])
    else $error("memory end data moved during the clock high phase");
  a_no_contention: assert property (!(scl && sda_m_oe && sda_s_oe))
    else $error("both ends drive the data line in one clock high phase");
  a_nack_release: assert property (rise && st.bitc == 4'h8 && sda |=> dev_quiet)
    else $error("memory end drove the line after an unanswered slot");
  a_start_quiet: assert property (start |=> dev_quiet)
    else $error("memory end drove the line right after a start");
  a_stop_quiet: assert property (stop |=> dev_quiet)
    else $error("memory end drove the line after a stop");
  a_ctrl_listen: assert property (rise && st.ctrl && st.bitc != 4'h8 |-> !sda_s_oe)
    else $error("memory end drove the line during a control byte bit");
  a_stop_idle: assert property (stop |=> (scl && sda) [*2])
    else $error("link did not rest high after a stop");
endmodule : sep_link_properties

//--- tb.sv
// Self-checking bench: host end and memory end joined over the link.
`timescale 1ns/1ps
module tb;
  import sep_pkg::*;
  localparam int HC = 8;
  logic                  ref_clk, rst, cmd_valid, cmd_random, prog_busy;
  logic                  cmd_ready, rd_valid, done, nack, reading, byte_sent;
  logic [2:0]            cmd_cs, cs_strap;
  logic [7:0]            cmd_len, rd_byte, rd_data;
  logic [SEP_ADDR_W-1:0] cmd_addr, rd_addr, ptr;
  logic [7:0]            mem [0:32767];
  logic [7:0]            exp_q [$];
  logic                  exp_nack_q [$];
  int                    err_total, tests_run;
  int                    sent_n = 0;
  int                    exp_sent;

  sep_link_if link_inst ();
  sep_host #(.HALF_CYC(HC)) sep_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link_inst),
    .cmd_valid(cmd_valid), .cmd_random(cmd_random), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .done(done), .nack(nack));
  sep_dev sep_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link_inst),
    .chip_select_inputs(cs_strap), .prog_busy(prog_busy), .rd_data(rd_data),
    .rd_addr(rd_addr), .reading(reading), .byte_sent(byte_sent));
  sep_link_properties sep_link_properties_inst (.ref_clk(ref_clk), .rst(rst),
    .scl(link_inst.scl), .sda_m_o(link_inst.sda_m_o), .sda_m_oe(link_inst.sda_m_oe),
    .sda_s_o(link_inst.sda_s_o), .sda_s_oe(link_inst.sda_s_oe), .sda(link_inst.sda));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // The memory array answers within half a cycle of a pointer move.
  always @(negedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag

  task automatic check_addr(input logic [14:0] got, input logic [14:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_addr

  task automatic wait_hi(ref logic sig, input int lim);
    int k;
    k = 0;
    while (sig !== 1'b1) begin
      @(negedge ref_clk);
      k++;
      if (k > lim) begin
        check_flag(sig, 1'b1);
        end_of_test();
      end
    end
  endtask : wait_hi

  // A failing command leaves the pointer where it was.
  task automatic run_cmd(input logic rnd, input logic [2:0] cs, input logic [14:0] a,
                         input logic [7:0] len, input logic fail);
    logic [14:0] p;
    p = rnd ? a : ptr;
    exp_nack_q.push_back(fail);
    if (!fail) begin
      for (int i = 0; i < ((len == 8'h00) ? 1 : int'(len)); i++) begin
        exp_q.push_back(mem[p]);
        p = p + 15'h1;
      end
      ptr = p;
      exp_sent += (len == 8'h00) ? 1 : int'(len);
    end
    @(negedge ref_clk);
    cmd_random = rnd;
    cmd_cs = cs;
    cmd_addr = a;
    cmd_len = len;
    cmd_valid = 1'b1;
    wait_hi(cmd_ready, 100);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_hi(done, 4000);
    check_addr(rd_addr, ptr);
    check_flag(reading, 1'b0);
  endtask : run_cmd

  always @(negedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      check_flag(reading, 1'b1);
      if (exp_q.size() > 0) check_byte(rd_byte, exp_q.pop_front());
      else check_flag(1'b1, 1'b0);
    end
    if (byte_sent === 1'b1) sent_n++;
    if (done === 1'b1) begin
      if (exp_nack_q.size() > 0) check_flag(nack, exp_nack_q.pop_front());
      else check_flag(1'b1, 1'b0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_random = 1'b0;
    cmd_cs = 3'h0;
    cmd_addr = 15'h0000;
    cmd_len = 8'h00;
    cs_strap = 3'h5;
    prog_busy = 1'b0;
    ptr = SEP_PTR_RST;
    exp_sent = 0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h053b1632));
    for (int i = 0; i < 32768; i++) mem[i] = 8'($urandom());
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    run_cmd(1'b1, 3'h5, 15'h1234, 8'h01, 1'b0);
    run_cmd(1'b0, 3'h5, 15'h0000, 8'h01, 1'b0);
    run_cmd(1'b1, 3'h5, 15'h7ffe, 8'h04, 1'b0);
    run_cmd(1'b0, 3'h5, 15'h0000, 8'h00, 1'b0);
    run_cmd(1'b0, 3'h4, 15'h0000, 8'h01, 1'b1);
    run_cmd(1'b1, 3'h1, 15'h0100, 8'h01, 1'b1);
    prog_busy = 1'b1;
    run_cmd(1'b0, 3'h5, 15'h0000, 8'h01, 1'b1);
    run_cmd(1'b1, 3'h5, 15'h0200, 8'h02, 1'b1);
    prog_busy = 1'b0;
    run_cmd(1'b0, 3'h5, 15'h0000, 8'h02, 1'b0);
    for (int i = 0; i < 6; i++) begin
      cs_strap = 3'($urandom());
      run_cmd(1'b1, cs_strap, 15'($urandom()), 8'($urandom_range(1, 5)), 1'b0);
    end
    repeat (20) @(negedge ref_clk);
    check_byte(8'(exp_q.size()), 8'h00);
    check_byte(8'(exp_nack_q.size()), 8'h00);
    check_byte(8'(sent_n), 8'(exp_sent));
    end_of_test();
  end
endmodule : tb
